// ===== shared/scg_defines.svh
// Purpose: constants of the sleep clock gating controller
// Assumes: included by its bare name
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH
`define SCG_ADDR_W 4
`define SCG_OFS_CTRL 4'h0
`define SCG_OFS_STAT 4'h4
`define SCG_CTRL_PERMIT 0
`define SCG_CTRL_MODE_LO 1
`define SCG_CTRL_MODE_HI 3
`define SCG_CTRL_AS2 4
`define SCG_CTRL_JTD 5
`define SCG_CTRL_ADC 6
`define SCG_CTRL_COMP 7
`define SCG_CTRL_CREF 8
`define SCG_CTRL_WDT 9
`define SCG_CTRL_W 10
`define SCG_CTRL_RST 10'h000
`define SCG_STAT_REJECT 14
`define SCG_WAKE_STBY_CYC 8'h06
`define SCG_HALT_CYC 8'h04
`define SCG_WAKE_START_CYC 8'h10
`endif

// ===== shared/scg_pkg.sv
// Purpose: types of the sleep clock gating controller
// Assumes: nothing beyond the defines header
// Notes: mode codes follow the mode-select field
package scg_pkg;
    typedef enum logic [2:0] {
        SM_IDLE = 3'h0, SM_NOISE = 3'h1, SM_PDOWN = 3'h2, SM_PSAVE = 3'h3,
        SM_RSV4 = 3'h4, SM_RSV5 = 3'h5, SM_STBY = 3'h6, SM_XSTBY = 3'h7
    } scg_mode_t;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1, ST_SLEEP = 4'h2, ST_WAKE = 4'h4, ST_HALT = 4'h8
    } scg_state_t;
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic tosc;
    } scg_clk_t;
endpackage

// ===== shared/scg_reg_if.sv
// Purpose: register access path between bus slave and controller core
// Assumes: single clock
// Notes: decode answers are combinational
`timescale 1ns/100ps
interface scg_reg_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [3:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface

// ===== design/scg_axil.sv
// Purpose: AXI4-Lite slave for the controller registers
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer SLVERR
`timescale 1ns/100ps
module scg_axil (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // axi4-lite
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register side
    scg_reg_if.bus rif
);
    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [3:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scg_axil_t;
    scg_axil_t s_q, s_d;

    assign s_awready = !s_q.aw_have && !s_q.bvalid;
    assign s_wready = !s_q.w_have && !s_q.bvalid;
    assign s_arready = !s_q.rvalid;
    assign rif.rd_addr = s_araddr;
    assign rif.wr_addr = s_q.addr;
    assign rif.wr_data = s_q.data;
    assign rif.wr_strb = s_q.strb;
    assign rif.wr_en = s_q.aw_have && s_q.w_have && !s_q.bvalid;

    always_comb begin
        s_d = s_q;
        if (s_awvalid && s_awready) begin
            s_d.aw_have = 1'b1;
            s_d.addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            s_d.w_have = 1'b1;
            s_d.data = s_wdata;
            s_d.strb = s_wstrb;
        end
        if (rif.wr_en) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = rif.wr_ok ? 2'h0 : 2'h2;
        end
        if (s_q.bvalid && s_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rif.rd_ok ? rif.rd_data : 32'h0;
            s_d.rresp = rif.rd_ok ? 2'h0 : 2'h2;
        end else if (s_q.rvalid && s_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_bvalid = s_q.bvalid;
    assign s_bresp = s_q.bresp;
    assign s_rvalid = s_q.rvalid;
    assign s_rdata = s_q.rdata;
    assign s_rresp = s_q.rresp;
endmodule // scg_axil

// ===== design/scg_top.sv
// Purpose: sleep mode sequencer and clock/analog gating controller
// Assumes: all inputs synchronous to clk; gate cells latch enables on low phase
// Notes: wake start-up delay for non-standby modes is a parameter
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "scg_defines.svh"
module scg_top
    import scg_pkg::*;
#(
    parameter logic [7:0] WAKE_START_CYC = `SCG_WAKE_START_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // axi4-lite register bus
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // processor core
    input wire logic sleep_instr,
    output logic core_halt,
    output logic wake_resume,
    // fuses and clock option
    input wire logic ext_crystal_sel,
    input wire logic brownout_enable_fuse,
    input wire logic debug_enable_fuse,
    input wire logic scan_port_enable_fuse,
    // wake-up sources
    input wire logic ext_irq_line_zero,
    input wire logic ext_irq_line_one,
    input wire logic ext_irq_line_two,
    input wire logic ext_irq_level_mode,
    input wire logic two_wire_port_match,
    input wire logic timer2_irq,
    input wire logic self_program_store_ready,
    input wire logic converter_irq,
    input wire logic other_io_irq,
    // clock domain enables
    output logic core_clock_domain_en,
    output logic program_memory_clock_domain_en,
    output logic peripheral_io_clock_domain_en,
    output logic converter_clock_domain_en,
    output logic async_timer_clock_domain_en,
    output logic main_osc_en,
    output logic timer_osc_en,
    // analog and support blocks
    input wire logic conv_begin,
    output logic converter_en,
    output logic converter_start,
    output logic converter_extended,
    output logic comparator_en,
    output logic vref_en,
    output logic brownout_en,
    output logic watchdog_en,
    output logic input_buf_en,
    output logic wake_pin_buf_en,
    // scan port
    input wire logic tap_shifting,
    input wire logic tap_tdo_data,
    output logic scan_en,
    output logic scan_tdo_o,
    output logic scan_tdo_oe_n
);
    typedef struct packed {
        scg_state_t state;
        scg_mode_t mode;
        logic [7:0] cnt;
        logic [`SCG_CTRL_W-1:0] ctrl;
        logic reject;
        logic conv_ext;
        logic conv_prev;
        logic start;
        logic resume;
        scg_clk_t gate;
        logic comp;
        logic inbuf;
    } scg_top_t;
    scg_top_t s_q, s_d;
    scg_reg_if rif ();

    scg_axil u_axil (
        .clk(clk),
        .reset(reset),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rif(rif)
    );

    // domain plan while asleep in a mode
    function automatic scg_clk_t sleep_plan(scg_mode_t m, logic as2);
        scg_clk_t g;
        g = '0;
        unique case (m)
            SM_IDLE: begin
                g.io = 1'b1;
                g.adc = 1'b1;
                g.asy = 1'b1;
                g.main_osc = 1'b1;
                g.tosc = as2;
            end
            SM_NOISE: begin
                g.adc = 1'b1;
                g.asy = 1'b1;
                g.main_osc = 1'b1;
                g.tosc = as2;
            end
            SM_PSAVE: begin
                g.asy = as2;
                g.tosc = as2;
            end
            SM_STBY: begin
                g.main_osc = 1'b1;
            end
            SM_XSTBY: begin
                g.asy = as2;
                g.tosc = as2;
                g.main_osc = 1'b1;
            end
            default: begin
                g = '0;
            end
        endcase
        return g;
    endfunction

    // whether mode is one of the deep modes
    function automatic logic deep_mode(scg_mode_t m);
        return (m == SM_PDOWN) || (m == SM_PSAVE) || (m == SM_STBY) || (m == SM_XSTBY);
    endfunction

    logic as2, scan_port_disable_bit, conv_on, comp_on, comp_ref, wdt_on, permit;
    scg_mode_t mode_sel;
    logic mode_ok, ext_wake, wake_ev, asleep;
    logic [31:0] stat_word;

    assign permit = s_q.ctrl[`SCG_CTRL_PERMIT];
    assign mode_sel = scg_mode_t'(s_q.ctrl[`SCG_CTRL_MODE_HI:`SCG_CTRL_MODE_LO]);
    assign as2 = s_q.ctrl[`SCG_CTRL_AS2];
    assign scan_port_disable_bit = s_q.ctrl[`SCG_CTRL_JTD];
    assign conv_on = s_q.ctrl[`SCG_CTRL_ADC];
    assign comp_on = s_q.ctrl[`SCG_CTRL_COMP];
    assign comp_ref = s_q.ctrl[`SCG_CTRL_CREF];
    assign wdt_on = s_q.ctrl[`SCG_CTRL_WDT];
    assign scan_en = scan_port_enable_fuse && !scan_port_disable_bit;

    // reserved codes and standby without crystal never sleep
    assign mode_ok = !(mode_sel == SM_RSV4 || mode_sel == SM_RSV5)
        && (ext_crystal_sel || !(mode_sel == SM_STBY || mode_sel == SM_XSTBY));

    assign ext_wake = ext_irq_line_two
        || (ext_irq_level_mode && (ext_irq_line_zero || ext_irq_line_one));

    always_comb begin
        wake_ev = two_wire_port_match || ext_wake;
        unique case (s_q.mode)
            SM_IDLE: begin
                wake_ev = wake_ev || ext_irq_line_zero || ext_irq_line_one || timer2_irq
                    || self_program_store_ready || converter_irq || other_io_irq;
            end
            SM_NOISE: begin
                wake_ev = wake_ev || timer2_irq || self_program_store_ready || converter_irq;
            end
            SM_PSAVE, SM_XSTBY: begin
                wake_ev = wake_ev || (as2 && timer2_irq);
            end
            default: begin
                wake_ev = wake_ev;
            end
        endcase
    end

    assign stat_word = {15'h0, scan_en, s_q.conv_ext, s_q.reject, s_q.gate, s_q.mode, s_q.state};
    assign rif.rd_ok = (rif.rd_addr == `SCG_OFS_CTRL) || (rif.rd_addr == `SCG_OFS_STAT);
    assign rif.rd_data = (rif.rd_addr == `SCG_OFS_CTRL) ? {22'h0, s_q.ctrl} : stat_word;
    assign rif.wr_ok = (rif.wr_addr == `SCG_OFS_CTRL) || (rif.wr_addr == `SCG_OFS_STAT);

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.resume = 1'b0;
        if (rif.wr_en && rif.wr_addr == `SCG_OFS_CTRL) begin
            if (rif.wr_strb[0]) begin
                s_d.ctrl[7:0] = rif.wr_data[7:0];
            end
            if (rif.wr_strb[1]) begin
                s_d.ctrl[`SCG_CTRL_W-1:8] = rif.wr_data[`SCG_CTRL_W-1:8];
            end
        end
        if (rif.wr_en && rif.wr_addr == `SCG_OFS_STAT && rif.wr_strb[1]
            && rif.wr_data[`SCG_STAT_REJECT]) begin
            s_d.reject = 1'b0;
        end
        // converter turned back on: next conversion is long
        s_d.conv_prev = conv_on;
        if (conv_begin || s_q.start) begin
            s_d.conv_ext = 1'b0;
        end
        if (conv_on && !s_q.conv_prev) begin
            s_d.conv_ext = 1'b1;
        end
        unique case (s_q.state)
            ST_RUN: begin
                if (sleep_instr && permit) begin
                    if (mode_ok) begin
                        s_d.state = ST_SLEEP;
                        s_d.mode = mode_sel;
                        s_d.start = conv_on && (mode_sel == SM_IDLE || mode_sel == SM_NOISE);
                    end else begin
                        s_d.reject = 1'b1;
                    end
                end
            end
            ST_SLEEP: begin
                if (wake_ev) begin
                    s_d.state = ST_WAKE;
                    s_d.cnt = (s_q.mode == SM_STBY || s_q.mode == SM_XSTBY)
                        ? `SCG_WAKE_STBY_CYC - 8'h01 : WAKE_START_CYC - 8'h01;
                end
            end
            ST_WAKE: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.state = ST_HALT;
                    s_d.cnt = `SCG_HALT_CYC - 8'h01;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            ST_HALT: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.state = ST_RUN;
                    s_d.resume = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
        endcase
        // enables registered so gate cells see them settle early in the high phase
        if (s_d.state == ST_RUN || s_d.state == ST_HALT) begin
            s_d.gate = '1;
            s_d.gate.tosc = as2;
            s_d.gate.asy = 1'b1;
        end else begin
            s_d.gate = sleep_plan(s_d.mode, as2);
            if (s_d.state == ST_WAKE) begin
                s_d.gate.main_osc = 1'b1;
            end
            if (debug_enable_fuse && scan_en
                && (s_d.mode == SM_PDOWN || s_d.mode == SM_PSAVE)) begin
                s_d.gate.main_osc = 1'b1;
            end
        end
        s_d.comp = comp_on && !(s_d.state == ST_SLEEP && deep_mode(s_d.mode));
        s_d.inbuf = !(s_d.state == ST_SLEEP && !s_d.gate.io && !s_d.gate.adc);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '{state: ST_RUN, mode: SM_IDLE, cnt: 8'h00, ctrl: `SCG_CTRL_RST,
                     reject: 1'b0, conv_ext: 1'b0, conv_prev: 1'b0, start: 1'b0,
                     resume: 1'b0, gate: 7'h7D, comp: 1'b0, inbuf: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign asleep = s_q.state == ST_SLEEP;
    assign core_halt = s_q.state != ST_RUN;
    assign wake_resume = s_q.resume;
    assign core_clock_domain_en = s_q.gate.cpu;
    assign program_memory_clock_domain_en = s_q.gate.flash;
    assign peripheral_io_clock_domain_en = s_q.gate.io;
    assign converter_clock_domain_en = s_q.gate.adc;
    assign async_timer_clock_domain_en = s_q.gate.asy;
    assign main_osc_en = s_q.gate.main_osc;
    assign timer_osc_en = s_q.gate.tosc;
    assign converter_en = conv_on;
    assign converter_start = s_q.start;
    assign converter_extended = s_q.conv_ext;
    assign comparator_en = s_q.comp;
    assign vref_en = brownout_enable_fuse || (comp_on && comp_ref) || conv_on;
    assign brownout_en = brownout_enable_fuse;
    assign watchdog_en = wdt_on;
    assign input_buf_en = s_q.inbuf;
    assign wake_pin_buf_en = 1'b1;
    assign scan_tdo_oe_n = !(scan_en && tap_shifting);
    assign scan_tdo_o = scan_tdo_oe_n ? 1'b0 : tap_tdo_data;

    stby_wake_six_a: assert property (@(posedge clk) disable iff (reset)
        (asleep && wake_ev && (s_q.mode == SM_STBY || s_q.mode == SM_XSTBY))
        |=> (s_q.state == ST_WAKE) [*6] ##1 (s_q.state == ST_HALT))
        else $error("standby wake did not take six cycles");
    halt_four_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == ST_WAKE && s_q.cnt == 8'h00)
        |=> (core_halt && s_q.state == ST_HALT) [*4] ##1 (!core_halt && wake_resume))
        else $error("halt after wake not four cycles");
    sleep_permit_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == ST_RUN && (!sleep_instr || !permit || !mode_ok))
        |=> s_q.state == ST_RUN)
        else $error("sleep entered without permit or with bad mode");
    xstby_main_a: assert property (@(posedge clk) disable iff (reset)
        (asleep && s_q.mode == SM_XSTBY)
        |-> (main_osc_en && async_timer_clock_domain_en == as2 && !peripheral_io_clock_domain_en))
        else $error("extended standby gating wrong");
    core_gated_a: assert property (@(posedge clk) disable iff (reset)
        asleep |-> (!core_clock_domain_en && !program_memory_clock_domain_en))
        else $error("core clock running in sleep");
    deep_wake_a: assert property (@(posedge clk) disable iff (reset)
        (asleep && s_q.mode == SM_PDOWN && !two_wire_port_match && !ext_irq_line_two
         && !ext_irq_level_mode) |=> asleep)
        else $error("power-down woke from a masked source");
    comp_off_a: assert property (@(posedge clk) disable iff (reset)
        (asleep && deep_mode(s_q.mode)) |-> !comparator_en)
        else $error("comparator on in deep sleep");
    inbuf_off_a: assert property (@(posedge clk) disable iff (reset)
        (asleep && !peripheral_io_clock_domain_en && !converter_clock_domain_en)
        |-> !input_buf_en)
        else $error("input buffers left on");
    debug_hold_a: assert property (@(posedge clk) disable iff (reset)
        (asleep && s_q.mode == SM_PDOWN && debug_enable_fuse && scan_en) |-> main_osc_en)
        else $error("debug fuse did not hold main source");
    tdo_float_a: assert property (@(posedge clk) disable iff (reset)
        (!tap_shifting || !scan_en) |-> scan_tdo_oe_n)
        else $error("scan output driven while idle");
    conv_ext_a: assert property (@(posedge clk) disable iff (reset)
        (conv_on && !s_q.conv_prev) |=> converter_extended)
        else $error("extended conversion not flagged");
    auto_start_a: assert property (@(posedge clk) disable iff (reset)
        (s_q.state == ST_RUN && sleep_instr && permit && mode_ok && conv_on
         && mode_sel == SM_IDLE) |=> converter_start)
        else $error("no conversion started on idle entry");
endmodule // scg_top

// ===== test/scg_core_model.sv
// Purpose: processor core side of the sleep controller
// Assumes: a request from the bench lasts one or more cycles
// Notes: only the sleep instruction is modelled
`timescale 1ns/100ps
module scg_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bench side
    input wire logic req,
    // controller side
    output logic sleep_instr
);
    logic req_q;
    // one pulse per request, as one executed sleep instruction
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_q <= 1'h0;
            sleep_instr <= 1'h0;
        end else begin
            req_q <= req;
            sleep_instr <= req & ~req_q;
        end
    end
endmodule // scg_core_model

// ===== test/sleep_clock_gating_controller_tb_top.sv
// Purpose: self-checking bench of the sleep clock gating controller
// Assumes: wake start-up shortened to 2 cycles
// Notes: gates reads {cpu,flash,io,adc,asy,main,tosc}
`timescale 1ns/100ps
module sleep_clock_gating_controller_tb_top;
    logic clk = 0, reset = 1, req = 0;
    logic [3:0] s_awaddr = 0, s_wstrb = 4'hF, s_araddr = 0;
    logic [31:0] s_wdata = 0, s_rdata, rdv;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sleep_instr, core_halt;
    logic [1:0] s_bresp, s_rresp, rsp;
    logic ext_crystal_sel = 1, brownout_enable_fuse = 0, debug_enable_fuse = 0;
    logic scan_port_enable_fuse = 1, ext_irq_line_zero = 0, ext_irq_line_one = 0;
    logic ext_irq_level_mode = 0, self_program_store_ready = 0, converter_irq = 0;
    logic other_io_irq = 0, conv_begin = 0, tap_shifting = 0, tap_tdo_data = 1;
    logic [2:0] wsrc = 0;
    wire timer2_irq, ext_irq_line_two, two_wire_port_match;
    logic wake_resume, core_clock_domain_en, program_memory_clock_domain_en;
    logic peripheral_io_clock_domain_en, converter_clock_domain_en, main_osc_en;
    logic async_timer_clock_domain_en, timer_osc_en, converter_en, converter_start;
    logic converter_extended, comparator_en, vref_en, brownout_en, watchdog_en;
    logic input_buf_en, wake_pin_buf_en, scan_en, scan_tdo_o, scan_tdo_oe_n;
    int error_cnt = 0, tests_run = 0, n_p, n_s, n;
    wire [6:0] gates = {core_clock_domain_en, program_memory_clock_domain_en,
        peripheral_io_clock_domain_en, converter_clock_domain_en,
        async_timer_clock_domain_en, main_osc_en, timer_osc_en};
    assign {timer2_irq, ext_irq_line_two, two_wire_port_match} = wsrc;
    always #12.5 clk = ~clk;
    scg_top #(.WAKE_START_CYC(8'h02)) u_dut (.*);
    scg_core_model u_core (.clk(clk), .reset(reset), .req(req), .sleep_instr(sleep_instr));
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task lim(input int k);
        if (k >= 60) begin
            error_cnt++;
            complete_run;
        end
    endtask
    // tasks start and end just after a rising edge; ready is looked at mid-cycle
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        n = 0;
        bh = 0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        while (!bh && n < 60) begin
            @(negedge clk);
            ah = s_awvalid & s_awready;
            wh = s_wvalid & s_wready;
            bh = s_bvalid;
            rsp = s_bresp;
            @(posedge clk);
            if (ah) s_awvalid <= 1'h0;
            if (wh) s_wvalid <= 1'h0;
            n++;
        end
        s_bready <= 1'h0;
        @(posedge clk);
        lim(n);
    endtask
    task rd(input logic [3:0] a);
        logic ah, rh;
        n = 0;
        rh = 0;
        s_araddr <= a;
        s_arvalid <= 1'h1;
        s_rready <= 1'h1;
        while (!rh && n < 60) begin
            @(negedge clk);
            ah = s_arvalid & s_arready;
            rh = s_rvalid;
            rdv = s_rdata;
            rsp = s_rresp;
            @(posedge clk);
            if (ah) s_arvalid <= 1'h0;
            n++;
        end
        s_rready <= 1'h0;
        @(posedge clk);
        lim(n);
    endtask
    task slp(input logic [31:0] c, input logic [6:0] eg, input logic eh, input logic es);
        logic st;
        st = 0;
        wr(4'h0, c);
        req <= 1'h1;
        @(posedge clk);
        req <= 1'h0;
        repeat (4) begin
            @(negedge clk);
            st = st | converter_start;
        end
        cmp(core_halt, eh);
        if (eh) cmp(gates, eg);
        cmp(st, es);
        @(posedge clk);
    endtask
    task wk(input logic [2:0] s, output int k);
        k = 0;
        wsrc <= s;
        while (k < 60 && wake_resume !== 1'h1) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        wsrc <= 3'h0;
        lim(k);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        cmp({core_halt, gates}, 32'h7D);
        rd(4'h0);
        cmp(rdv, 32'h0);
        rd(4'h8);
        cmp(rsp, 32'h2);
        wr(4'h8, 32'h0);
        cmp(rsp, 32'h2);
        slp(32'h3C1, 7'h1E, 1'h1, 1'h1);
        cmp({converter_en, vref_en, watchdog_en}, 32'h7);
        cmp({comparator_en, input_buf_en}, 32'h3);
        wk(3'h1, n);
        slp(32'h43, 7'h0E, 1'h1, 1'h1);
        wk(3'h1, n);
        slp(32'h17, 7'h05, 1'h1, 1'h0);
        wk(3'h4, n);
        slp(32'h385, 7'h00, 1'h1, 1'h0);
        cmp({comparator_en, input_buf_en, wake_pin_buf_en}, 32'h1);
        cmp({vref_en, watchdog_en}, 32'h3);
        ext_irq_line_zero <= 1'h1;
        repeat (6) @(negedge clk);
        cmp(core_halt, 32'h1);
        @(posedge clk);
        ext_irq_line_zero <= 1'h0;
        wk(3'h2, n_p);
        slp(32'h1F, 7'h07, 1'h1, 1'h0);
        cmp(vref_en, 32'h0);
        wk(3'h4, n_s);
        cmp(n_s - n_p, 32'h4);
        slp(32'h0D, 7'h02, 1'h1, 1'h0);
        ext_irq_level_mode <= 1'h1;
        ext_irq_line_one <= 1'h1;
        wk(3'h0, n);
        ext_irq_line_one <= 1'h0;
        cmp(n, n_s);
        slp(32'h09, 7'h00, 1'h0, 1'h0);
        ext_crystal_sel <= 1'h0;
        slp(32'h0D, 7'h00, 1'h0, 1'h0);
        rd(4'h4);
        cmp(rdv[14], 32'h1);
        wr(4'h4, 32'h4000);
        cmp(rsp, 32'h0);
        rd(4'h4);
        cmp(rdv[14], 32'h0);
        ext_crystal_sel <= 1'h1;
        debug_enable_fuse <= 1'h1;
        slp(32'h05, 7'h02, 1'h1, 1'h0);
        wk(3'h1, n);
        slp(32'h25, 7'h00, 1'h1, 1'h0);
        cmp(scan_en, 32'h0);
        wk(3'h1, n);
        wr(4'h0, 32'h40);
        cmp(rsp, 32'h0);
        brownout_enable_fuse <= 1'h1;
        @(negedge clk);
        cmp({scan_tdo_oe_n, brownout_en, converter_extended}, 32'h7);
        @(posedge clk);
        tap_shifting <= 1'h1;
        @(negedge clk);
        cmp({scan_tdo_oe_n, scan_tdo_o}, 32'h1);
        @(posedge clk);
        complete_run;
    end
endmodule // sleep_clock_gating_controller_tb_top
